// File: hltr_pkg.sv
// package for the holdover tuning and lock detect register bank
package hltr_pkg;
  // ----------------------------------------------------------------
  // register offsets (word index on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [4:0] OFS_HOLD = 5'h0f;
  localparam logic [4:0] OFS_XTAL = 5'h10;
  localparam logic [4:0] OFS_TRACK = 5'h17;
  localparam logic [4:0] OFS_FILT = 5'h18;
  localparam logic [4:0] OFS_TCLK = 5'h19;
  localparam logic [4:0] OFS_LOOP2 = 5'h1a;
  localparam logic [4:0] OFS_CTRL = 5'h1f;
  localparam logic [4:0] OFS_STAT = 5'h1e;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int MAN_CODE_LSB = 22;
  localparam int MAN_SEL_BIT = 20;
  localparam int EXIT_CNT_LSB = 6;
  localparam int FORCE_BIT = 5;
  localparam int XTAL_LSB = 22;
  localparam int TRACK_LSB = 14;
  localparam int CAP4_LSB = 28;
  localparam int CAP3_LSB = 24;
  localparam int RES4_LSB = 20;
  localparam int RES3_LSB = 16;
  localparam int FB_DLY_LSB = 12;
  localparam int REF_DLY_LSB = 8;
  localparam int WIN1_LSB = 6;
  localparam int TDIV_LSB = 22;
  localparam int LOCK1_CNT_LSB = 6;
  localparam int WIN2_LSB = 30;
  localparam int DBL_BIT = 29;
  localparam int POL_BIT = 28;
  localparam int GAIN_LSB = 26;
  localparam int LOCK2_CNT_LSB = 6;
  localparam int FLOAT_BIT = 5;
  localparam int TRACK_EN_BIT = 0;
  localparam int RAIL_EN_BIT = 1;
  localparam int SWDIS_BIT = 2;
  // ----------------------------------------------------------------
  // reset values and limits
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_HOLD = 32'h00000040;
  localparam logic [31:0] RST_XTAL = 32'h00000000;
  localparam logic [31:0] RST_FILT = 32'h00000000;
  localparam logic [31:0] RST_TCLK = 32'h00400040;
  localparam logic [31:0] RST_LOOP2 = 32'h80000040;
  localparam logic [31:0] RST_CTRL = 32'h00000000;
  localparam logic [3:0] CAP_MAX = 4'hd;
  localparam logic [2:0] RES_MAX = 3'h4;
  localparam logic [1:0] WIN2_ONLY = 2'h2;
  // delay step in ps; 250 MHz core clock period in ps
  localparam int DLY_STEP_PS = 205;
  localparam int CLK_PERIOD_PS = 4000;
  // window sizes in ps: 5.5, 10, 18.6, 40 ns
  localparam int WIN_PS0 = 5500;
  localparam int WIN_PS1 = 10000;
  localparam int WIN_PS2 = 18600;
  localparam int WIN_PS3 = 40000;
  localparam int WIN2_PS = 3700;
  // pump currents in uA
  localparam logic [11:0] PUMP_UA0 = 12'h064;
  localparam logic [11:0] PUMP_UA1 = 12'h190;
  localparam logic [11:0] PUMP_UA2 = 12'h640;
  localparam logic [11:0] PUMP_UA3 = 12'hc80;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [15:0] err_ps;
  } hltr_phase_t;
  typedef struct packed {
    logic polarity_pos;
    logic float_out;
    logic [11:0] current_ua;
  } hltr_pump_t;
  typedef enum logic [1:0] {
    HLTR_TRACK_MODE, HLTR_MANUAL_MODE, HLTR_HOLD_TRACK, HLTR_HOLD_MANUAL
  } hltr_dac_mode_t;
endpackage

// File: hltr_regs.sv
// holdover tuning, lock detect and loop configuration register bank
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/10ps
module hltr_regs (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  input wire logic pd1_tick_in,
  input wire logic [15:0] pd1_err_ps_in,
  input wire logic pd2_tick_in,
  input wire logic [15:0] pd2_err_ps_in,
  input wire logic [9:0] track_code_in,
  output logic [9:0] dac_code_out,
  output logic dac_update_out,
  output logic holdover_out,
  output logic switch_event_out,
  output logic lock1_out,
  output logic lock2_out,
  output logic [1:0] xtal_level_out,
  output logic [10:0] fb_delay_ps_out,
  output logic [10:0] ref_delay_ps_out,
  output logic [13:0] filter_codes_out,
  output logic ref_double_out,
  output logic pump_pos_out,
  output logic pump_float_out,
  output logic [11:0] pump_ua_out
);
  // ----------------------------------------------------------------
  // reset release and input synchronisers
  // ----------------------------------------------------------------
  logic rst_s1, rst_n;
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
    end
  end

  // detector ticks and errors come from the loop domains
  logic [16:0] p1_s1, p1_s2, p2_s1, p2_s2;
  logic [9:0] trk_s1, trk_s2;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      p1_s1 <= 17'h00000;
      p1_s2 <= 17'h00000;
      p2_s1 <= 17'h00000;
      p2_s2 <= 17'h00000;
      trk_s1 <= 10'h000;
      trk_s2 <= 10'h000;
    end else begin
      p1_s1 <= {pd1_tick_in, pd1_err_ps_in};
      p1_s2 <= p1_s1;
      p2_s1 <= {pd2_tick_in, pd2_err_ps_in};
      p2_s2 <= p2_s1;
      trk_s1 <= track_code_in;
      trk_s2 <= trk_s1;
    end
  end
  hltr_pkg::hltr_phase_t ph1, ph2;
  logic t1_d, t2_d;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      t1_d <= 1'b0;
      t2_d <= 1'b0;
    end else begin
      t1_d <= p1_s2[16];
      t2_d <= p2_s2[16];
    end
  end
  // one comparison per rising edge of the synchronised tick
  assign ph1 = '{valid: p1_s2[16] & ~t1_d, err_ps: p1_s2[15:0]};
  assign ph2 = '{valid: p2_s2[16] & ~t2_d, err_ps: p2_s2[15:0]};

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] hold_r, xtal_r, filt_r, tclk_r, loop2_r, ctrl_r;
  logic [31:0] next_filt;
  logic [3:0] c4, c3;
  logic [2:0] r4, r3;
  always_comb begin
    c4 = wdata_in[hltr_pkg::CAP4_LSB +: 4];
    c3 = wdata_in[hltr_pkg::CAP3_LSB +: 4];
    r4 = wdata_in[hltr_pkg::RES4_LSB +: 3];
    r3 = wdata_in[hltr_pkg::RES3_LSB +: 3];
    next_filt = wdata_in;
    // a reserved code keeps the previous field
    if (c4 > hltr_pkg::CAP_MAX) next_filt[hltr_pkg::CAP4_LSB +: 4] = filt_r[hltr_pkg::CAP4_LSB +: 4];
    if (c3 > hltr_pkg::CAP_MAX) next_filt[hltr_pkg::CAP3_LSB +: 4] = filt_r[hltr_pkg::CAP3_LSB +: 4];
    if (r4 > hltr_pkg::RES_MAX) next_filt[hltr_pkg::RES4_LSB +: 3] = filt_r[hltr_pkg::RES4_LSB +: 3];
    if (r3 > hltr_pkg::RES_MAX) next_filt[hltr_pkg::RES3_LSB +: 3] = filt_r[hltr_pkg::RES3_LSB +: 3];
  end

  // register writes; zero counts and divisors are reserved and ignored
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_r <= hltr_pkg::RST_HOLD;
      xtal_r <= hltr_pkg::RST_XTAL;
      filt_r <= hltr_pkg::RST_FILT;
      tclk_r <= hltr_pkg::RST_TCLK;
      loop2_r <= hltr_pkg::RST_LOOP2;
      ctrl_r <= hltr_pkg::RST_CTRL;
    end else if (wr_in) begin
      unique case (addr_in)
        hltr_pkg::OFS_HOLD: begin
          if (wdata_in[hltr_pkg::EXIT_CNT_LSB +: 14] != 14'h0000) hold_r <= wdata_in;
        end
        hltr_pkg::OFS_XTAL: xtal_r <= wdata_in;
        hltr_pkg::OFS_FILT: filt_r <= next_filt;
        hltr_pkg::OFS_TCLK: begin
          if (wdata_in[hltr_pkg::TDIV_LSB +: 10] != 10'h000 &&
              wdata_in[hltr_pkg::LOCK1_CNT_LSB +: 14] != 14'h0000) tclk_r <= wdata_in;
        end
        hltr_pkg::OFS_LOOP2: begin
          if (wdata_in[hltr_pkg::LOCK2_CNT_LSB +: 14] != 14'h0000) loop2_r <= wdata_in;
        end
        hltr_pkg::OFS_CTRL: ctrl_r <= wdata_in;
        default: ;
      endcase
    end
  end

  // field views
  logic [9:0] man_code, tdiv;
  logic man_sel, force_hold, track_en, rail_en, sw_dis;
  logic [13:0] exit_cnt, lock1_cnt, lock2_cnt;
  logic [1:0] win1;
  assign man_code = hold_r[hltr_pkg::MAN_CODE_LSB +: 10];
  assign man_sel = hold_r[hltr_pkg::MAN_SEL_BIT];
  assign exit_cnt = hold_r[hltr_pkg::EXIT_CNT_LSB +: 14];
  assign force_hold = hold_r[hltr_pkg::FORCE_BIT];
  assign tdiv = tclk_r[hltr_pkg::TDIV_LSB +: 10];
  assign lock1_cnt = tclk_r[hltr_pkg::LOCK1_CNT_LSB +: 14];
  assign lock2_cnt = loop2_r[hltr_pkg::LOCK2_CNT_LSB +: 14];
  assign win1 = filt_r[hltr_pkg::WIN1_LSB +: 2];
  assign track_en = ctrl_r[hltr_pkg::TRACK_EN_BIT];
  assign rail_en = ctrl_r[hltr_pkg::RAIL_EN_BIT];
  assign sw_dis = ctrl_r[hltr_pkg::SWDIS_BIT];

  // ----------------------------------------------------------------
  // lock detectors
  // ----------------------------------------------------------------
  logic [15:0] win1_ps;
  always_comb begin
    unique case (win1)
      2'h0: win1_ps = 16'(hltr_pkg::WIN_PS0);
      2'h1: win1_ps = 16'(hltr_pkg::WIN_PS1);
      2'h2: win1_ps = 16'(hltr_pkg::WIN_PS2);
      2'h3: win1_ps = 16'(hltr_pkg::WIN_PS3);
    endcase
  end

  logic [13:0] cnt1, cnt2;
  logic lock1, lock2;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt1 <= 14'h0000;
      lock1 <= 1'b0;
    end else if (ph1.valid) begin
      if (ph1.err_ps < win1_ps) begin
        if (cnt1 != 14'h3fff) cnt1 <= cnt1 + 14'h0001;
        if (cnt1 + 14'h0001 >= lock1_cnt) lock1 <= 1'b1;
      end else begin
        cnt1 <= 14'h0000;
        lock1 <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      cnt2 <= 14'h0000;
      lock2 <= 1'b0;
    end else if (ph2.valid) begin
      if (ph2.err_ps < 16'(hltr_pkg::WIN2_PS)) begin
        if (cnt2 != 14'h3fff) cnt2 <= cnt2 + 14'h0001;
        if (cnt2 + 14'h0001 >= lock2_cnt) lock2 <= 1'b1;
      end else begin
        cnt2 <= 14'h0000;
        lock2 <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // holdover state
  // ----------------------------------------------------------------
  logic lock1_d, in_hold;
  logic [13:0] exit_run;
  logic lock_fall;
  assign lock_fall = lock1_d & ~lock1;
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      lock1_d <= 1'b0;
      in_hold <= 1'b0;
      exit_run <= 14'h0000;
      switch_event_out <= 1'b0;
    end else begin
      lock1_d <= lock1;
      // a lock1 flag fall switches input unless disabled
      switch_event_out <= lock_fall & ~sw_dis;
      // lock loss enters holdover only when switching is not disabled (sw_dis clear)
      if (lock_fall && !sw_dis) begin
        in_hold <= 1'b1;
        exit_run <= 14'h0000;
      end else if (in_hold && ph1.valid) begin
        // exit after lock held for exit count
        if (!lock1) exit_run <= 14'h0000;
        else if (exit_run + 14'h0001 >= exit_cnt) begin
          in_hold <= 1'b0;
          exit_run <= 14'h0000;
        end else exit_run <= exit_run + 14'h0001;
      end
    end
  end
  assign holdover_out = in_hold | force_hold;

  // ----------------------------------------------------------------
  // tuning converter
  // ----------------------------------------------------------------
  logic [9:0] div_cnt, held_code;
  logic upd;
  // update enable every divisor detector ticks
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 10'h000;
      upd <= 1'b0;
    end else begin
      upd <= 1'b0;
      if (ph1.valid) begin
        if (div_cnt + 10'h001 >= tdiv) begin
          div_cnt <= 10'h000;
          upd <= 1'b1;
        end else div_cnt <= div_cnt + 10'h001;
      end
    end
  end

  hltr_pkg::hltr_dac_mode_t mode;
  always_comb begin
    if (man_sel) mode = holdover_out ? hltr_pkg::HLTR_HOLD_MANUAL : hltr_pkg::HLTR_MANUAL_MODE;
    else mode = (holdover_out && track_en && !rail_en) ? hltr_pkg::HLTR_HOLD_TRACK
                                                       : hltr_pkg::HLTR_TRACK_MODE;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      held_code <= 10'h000;
      dac_code_out <= 10'h000;
      dac_update_out <= 1'b0;
    end else begin
      dac_update_out <= upd;
      // tracked value latched outside holdover
      if (upd && !holdover_out) held_code <= trk_s2;
      if (upd) begin
        unique case (mode)
          hltr_pkg::HLTR_MANUAL_MODE: dac_code_out <= man_code;
          hltr_pkg::HLTR_HOLD_MANUAL: dac_code_out <= man_code;
          hltr_pkg::HLTR_HOLD_TRACK: dac_code_out <= held_code;
          hltr_pkg::HLTR_TRACK_MODE: dac_code_out <= trk_s2;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // configuration outputs
  // ----------------------------------------------------------------
  hltr_pkg::hltr_pump_t pump;
  logic [1:0] gain;
  assign gain = loop2_r[hltr_pkg::GAIN_LSB +: 2];
  // pump polarity, float and current table
  always_comb begin
    pump.polarity_pos = loop2_r[hltr_pkg::POL_BIT];
    pump.float_out = loop2_r[hltr_pkg::FLOAT_BIT];
    unique case (gain)
      2'h0: pump.current_ua = hltr_pkg::PUMP_UA0;
      2'h1: pump.current_ua = hltr_pkg::PUMP_UA1;
      2'h2: pump.current_ua = hltr_pkg::PUMP_UA2;
      2'h3: pump.current_ua = hltr_pkg::PUMP_UA3;
    endcase
    if (pump.float_out) pump.current_ua = 12'h000;
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      xtal_level_out <= 2'h0;
      fb_delay_ps_out <= 11'h000;
      ref_delay_ps_out <= 11'h000;
      filter_codes_out <= 14'h0000;
      ref_double_out <= 1'b0;
      pump_pos_out <= 1'b0;
      pump_float_out <= 1'b0;
      pump_ua_out <= 12'h000;
      lock1_out <= 1'b0;
      lock2_out <= 1'b0;
    end else begin
      xtal_level_out <= xtal_r[hltr_pkg::XTAL_LSB +: 2];
      fb_delay_ps_out <= 11'(filt_r[hltr_pkg::FB_DLY_LSB +: 3] * hltr_pkg::DLY_STEP_PS);
      ref_delay_ps_out <= 11'(filt_r[hltr_pkg::REF_DLY_LSB +: 3] * hltr_pkg::DLY_STEP_PS);
      filter_codes_out <= {filt_r[31:24], filt_r[22:20], filt_r[18:16]};
      ref_double_out <= loop2_r[hltr_pkg::DBL_BIT];
      pump_pos_out <= pump.polarity_pos;
      pump_float_out <= pump.float_out;
      pump_ua_out <= pump.current_ua;
      lock1_out <= lock1;
      lock2_out <= lock2;
    end
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      rdata_out <= 32'h00000000;
    end else if (rd_in) begin
      unique case (addr_in)
        hltr_pkg::OFS_HOLD: rdata_out <= hold_r;
        hltr_pkg::OFS_XTAL: rdata_out <= xtal_r;
        hltr_pkg::OFS_TRACK: rdata_out <= {8'h00, held_code, 14'h0000};
        hltr_pkg::OFS_FILT: rdata_out <= filt_r;
        hltr_pkg::OFS_TCLK: rdata_out <= tclk_r;
        hltr_pkg::OFS_LOOP2: rdata_out <= loop2_r;
        hltr_pkg::OFS_CTRL: rdata_out <= ctrl_r;
        hltr_pkg::OFS_STAT: rdata_out <= {28'h0000000, lock2, lock1, in_hold, holdover_out};
        default: rdata_out <= 32'h00000000;
      endcase
    end else begin
      rdata_out <= 32'h00000000;
    end
  end
endmodule

// File: hltr_regs_properties.sv
// assertions on the holdover and lock register bank ports
`timescale 1ns/10ps
module hltr_regs_properties (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic [4:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  input wire logic holdover_out,
  input wire logic [1:0] xtal_level_out,
  input wire logic [10:0] fb_delay_ps_out,
  input wire logic [13:0] filter_codes_out,
  input wire logic pump_pos_out,
  input wire logic pump_float_out,
  input wire logic [11:0] pump_ua_out
);
  // ------------------------------------------------------------
  // clocking and helpers
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [2:0] up;
  // cycles since reset release, saturating; outputs are zero while it is below 3
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up <= 3'h0;
    end else if (up != 3'h7) begin
      up <= up + 3'h1;
    end
  end
  // a write strobe to one offset
  sequence s_wr(logic [4:0] a);
    wr_in && addr_in == a;
  endsequence
  // a write whose count field is nonzero, so it is not dropped
  sequence s_wr_cnt(logic [4:0] a);
    s_wr(a) ##0 wdata_in[19:6] != 14'h0;
  endsequence
  rdata_idle_a: assert property (
    up == 3'h7 && !$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not idle");
  pump_float_a: assert property (
    up == 3'h7 && pump_float_out |-> pump_ua_out == 12'h0)
    else $error("floating pump shows current");
  pump_table_a: assert property (
    up == 3'h7 && !pump_float_out |-> pump_ua_out inside {12'h064, 12'h190, 12'h640, 12'hc80})
    else $error("pump current off table");
  pump_pol_a: assert property (
    s_wr_cnt(hltr_pkg::OFS_LOOP2) |-> ##2 pump_pos_out == $past(wdata_in[28], 2))
    else $error("pump polarity not taken");
  xtal_follow_a: assert property (
    s_wr(hltr_pkg::OFS_XTAL) |-> ##2 xtal_level_out == $past(wdata_in[23:22], 2))
    else $error("drive level not taken");
  fb_delay_a: assert property (
    s_wr(hltr_pkg::OFS_FILT) |-> ##2 fb_delay_ps_out == 11'($past(wdata_in[14:12], 2)) * 11'h0cd)
    else $error("feedback delay wrong");
  cap_keep_a: assert property (
    s_wr(hltr_pkg::OFS_FILT) ##0 wdata_in[31:28] > hltr_pkg::CAP_MAX
      |-> ##2 $stable(filter_codes_out[13:10]))
    else $error("reserved capacitor code taken");
  force_hold_a: assert property (
    s_wr_cnt(hltr_pkg::OFS_HOLD) ##0 wdata_in[5] |=> holdover_out)
    else $error("forced holdover not shown");
endmodule
bind hltr_regs hltr_regs_properties props_i (
  .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .holdover_out(holdover_out),
  .xtal_level_out(xtal_level_out), .fb_delay_ps_out(fb_delay_ps_out),
  .filter_codes_out(filter_codes_out), .pump_pos_out(pump_pos_out),
  .pump_float_out(pump_float_out), .pump_ua_out(pump_ua_out)
);

// File: hltr_regs_bench.sv
// self-checking bench for the holdover and lock register bank
`timescale 1ns/10ps
module hltr_regs_bench;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] addr_in = 5'h00;
  logic [31:0] wdata_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic pd1_tick_in = 1'b0;
  logic pd2_tick_in = 1'b0;
  logic [15:0] pd1_err_ps_in = 16'h0;
  logic [15:0] pd2_err_ps_in = 16'h0;
  logic [9:0] track_code_in = 10'h0;
  logic [31:0] rdata_out;
  logic [9:0] dac_code_out;
  logic dac_update_out, holdover_out, switch_event_out, lock1_out, lock2_out;
  logic [1:0] xtal_level_out;
  logic [10:0] fb_delay_ps_out, ref_delay_ps_out;
  logic [13:0] filter_codes_out;
  logic ref_double_out, pump_pos_out, pump_float_out;
  logic [11:0] pump_ua_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int n_switch = 0;
  int n_upd = 0;
  hltr_regs uut (
    .clk_in(clk_in), .resetn_in(resetn_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .pd1_tick_in(pd1_tick_in),
    .pd1_err_ps_in(pd1_err_ps_in), .pd2_tick_in(pd2_tick_in), .pd2_err_ps_in(pd2_err_ps_in),
    .track_code_in(track_code_in), .dac_code_out(dac_code_out),
    .dac_update_out(dac_update_out), .holdover_out(holdover_out),
    .switch_event_out(switch_event_out), .lock1_out(lock1_out), .lock2_out(lock2_out),
    .xtal_level_out(xtal_level_out), .fb_delay_ps_out(fb_delay_ps_out),
    .ref_delay_ps_out(ref_delay_ps_out), .filter_codes_out(filter_codes_out),
    .ref_double_out(ref_double_out), .pump_pos_out(pump_pos_out),
    .pump_float_out(pump_float_out), .pump_ua_out(pump_ua_out)
  );
  // 250 MHz clock
  initial begin
    forever #2 clk_in = ~clk_in;
  end
  // count one-cycle event and update pulses
  always @(posedge clk_in) begin
    if (switch_event_out === 1'b1) n_switch <= n_switch + 1;
    if (dac_update_out === 1'b1) n_upd <= n_upd + 1;
  end
  // ------------------------------------------------------------
  // bus, detector and check tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // one-cycle write, then let derived outputs settle
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  // one-cycle read, data taken in the following cycle only
  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 q = rdata_out;
  endtask
  // one detector comparison with error e; long enough for sync and lock
  task automatic tick(input logic two, input logic [15:0] e);
    @(posedge clk_in);
    if (two) pd2_err_ps_in <= e;
    else pd1_err_ps_in <= e;
    @(posedge clk_in);
    if (two) pd2_tick_in <= 1'b1;
    else pd1_tick_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    if (two) pd2_tick_in <= 1'b0;
    else pd1_tick_in <= 1'b0;
    repeat (6) @(posedge clk_in);
    #1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] q;
    logic [4:0] a [6] = '{hltr_pkg::OFS_HOLD, hltr_pkg::OFS_XTAL, hltr_pkg::OFS_FILT,
      hltr_pkg::OFS_TCLK, hltr_pkg::OFS_LOOP2, 5'h05};
    logic [31:0] v [6] = '{32'h40, 32'h0, 32'h0, 32'h00400040, 32'h80000040, 32'h0};
    wr(5'h05, 32'hffffffff);
    wr(5'h1b, 32'hffffffff);
    for (int i = 0; i < 6; i++) begin
      rd(a[i], q);
      chk(q, v[i]);
    end
  endtask
  task automatic t_filt();
    logic [31:0] q;
    wr(hltr_pkg::OFS_FILT, 32'hd5427300);
    chk(32'(filter_codes_out), 32'({4'hd, 4'h5, 3'h4, 3'h2}));
    chk(32'(fb_delay_ps_out), 32'h59b);
    chk(32'(ref_delay_ps_out), 32'h267);
    wr(hltr_pkg::OFS_FILT, 32'he65110c0);
    chk(32'(filter_codes_out), 32'({4'hd, 4'h6, 3'h4, 3'h1}));
    chk(32'(fb_delay_ps_out), 32'h0cd);
    rd(hltr_pkg::OFS_FILT, q);
    chk(q, 32'hd64110c0);
  endtask
  task automatic t_pump();
    logic [11:0] ua [4] = '{12'h064, 12'h190, 12'h640, 12'hc80};
    logic [31:0] w;
    for (int g = 0; g < 4; g++) begin
      w = 32'h80000040 | (32'(g) << 26) | (32'(g & 1) << 28) | (32'(g >> 1) << 29);
      wr(hltr_pkg::OFS_LOOP2, w);
      wr(hltr_pkg::OFS_XTAL, 32'(g) << 22);
      chk(32'(pump_ua_out), 32'(ua[g]));
      chk(32'(pump_pos_out), 32'(g & 1));
      chk(32'(ref_double_out), 32'(g >> 1));
      chk(32'(xtal_level_out), 32'(g));
    end
    wr(hltr_pkg::OFS_LOOP2, 32'h8c000060);
    chk(32'(pump_ua_out), 32'h0);
    chk(32'(pump_float_out), 32'h1);
  endtask
  task automatic t_lock();
    wr(hltr_pkg::OFS_CTRL, 32'h4);
    wr(hltr_pkg::OFS_FILT, 32'h0);
    wr(hltr_pkg::OFS_TCLK, 32'h004000c0);
    tick(1'b0, 16'h157b);
    tick(1'b0, 16'h157b);
    chk(32'(lock1_out), 32'h0);
    tick(1'b0, 16'h157b);
    chk(32'(lock1_out), 32'h1);
    tick(1'b0, 16'h157c);
    chk(32'(lock1_out), 32'h0);
    wr(hltr_pkg::OFS_FILT, 32'h000000c0);
    wr(hltr_pkg::OFS_TCLK, 32'h00400040);
    tick(1'b0, 16'h9c3f);
    chk(32'(lock1_out), 32'h1);
    tick(1'b0, 16'h9c40);
    chk(32'(lock1_out), 32'h0);
    wr(hltr_pkg::OFS_LOOP2, 32'h80000080);
    tick(1'b1, 16'h0e73);
    chk(32'(lock2_out), 32'h0);
    tick(1'b1, 16'h0e73);
    chk(32'(lock2_out), 32'h1);
    tick(1'b1, 16'h0e74);
    chk(32'(lock2_out), 32'h0);
  endtask
  task automatic t_hold();
    int s;
    wr(hltr_pkg::OFS_CTRL, 32'h0);
    wr(hltr_pkg::OFS_HOLD, 32'h000000c0);
    tick(1'b0, 16'h0100);
    s = n_switch;
    tick(1'b0, 16'h9c40);
    chk(32'(holdover_out), 32'h1);
    chk(32'(n_switch - s), 32'h1);
    repeat (2) begin
      tick(1'b0, 16'h0100);
      chk(32'(holdover_out), 32'h1);
    end
    repeat (2) tick(1'b0, 16'h0100);
    chk(32'(holdover_out), 32'h0);
    wr(hltr_pkg::OFS_CTRL, 32'h4);
    s = n_switch;
    tick(1'b0, 16'h9c40);
    chk(32'(holdover_out), 32'h0);
    wr(hltr_pkg::OFS_HOLD, 32'h000000e0);
    chk(32'(holdover_out), 32'h1);
    tick(1'b0, 16'h0100);
    tick(1'b0, 16'h9c40);
    chk(32'(n_switch - s), 32'h0);
    wr(hltr_pkg::OFS_HOLD, 32'h000000c0);
    chk(32'(holdover_out), 32'h0);
    wr(hltr_pkg::OFS_CTRL, 32'h0);
    tick(1'b0, 16'h0100);
    wr(hltr_pkg::OFS_HOLD, 32'h000000e0);
    tick(1'b0, 16'h9c40);
    chk(32'(n_switch - s), 32'h1);
    wr(hltr_pkg::OFS_HOLD, 32'h000000c0);
    repeat (4) tick(1'b0, 16'h0100);
  endtask
  task automatic t_dac();
    logic [31:0] q;
    int n;
    wr(hltr_pkg::OFS_CTRL, 32'h1);
    @(posedge clk_in);
    track_code_in <= 10'h155;
    tick(1'b0, 16'h0100);
    chk(32'(dac_code_out), 32'h155);
    rd(hltr_pkg::OFS_TRACK, q);
    chk(32'(q[23:14]), 32'h155);
    wr(hltr_pkg::OFS_HOLD, 32'h000000e0);
    @(posedge clk_in);
    track_code_in <= 10'h0aa;
    tick(1'b0, 16'h0100);
    chk(32'(dac_code_out), 32'h155);
    wr(hltr_pkg::OFS_CTRL, 32'h3);
    tick(1'b0, 16'h0100);
    chk(32'(dac_code_out), 32'h0aa);
    wr(hltr_pkg::OFS_HOLD, 32'ha95000e0);
    tick(1'b0, 16'h0100);
    chk(32'(dac_code_out), 32'h2a5);
    wr(hltr_pkg::OFS_HOLD, 32'hffd000c0);
    tick(1'b0, 16'h0100);
    chk(32'(dac_code_out), 32'h3ff);
    wr(hltr_pkg::OFS_TCLK, 32'h00c00040);
    n = n_upd;
    repeat (6) tick(1'b0, 16'h0100);
    chk(32'(n_upd - n), 32'h2);
    wr(hltr_pkg::OFS_TCLK, 32'h00000040);
    rd(hltr_pkg::OFS_TCLK, q);
    chk(q, 32'h00c00040);
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_in);
    resetn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    t_reset();
    t_filt();
    t_pump();
    t_lock();
    t_hold();
    t_dac();
    results();
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    results();
  end
endmodule
